/* File: design/cbb_bank.sv */
// Control and status byte bank of a two-output clock buffer, reached
// by indexed block reads and writes on a two-wire serial bus.
// Assumes a free reference clock; the bus clock may stop between frames.

module cbb_bank #(
   parameter logic [3:0] REV_CODE  = 4'h3,  // Arbitrary value
   parameter logic [3:0] MAKER     = 4'h9,  // Arbitrary value
   parameter logic [1:0] TYPE_CODE = 2'h2,  // Arbitrary value
   parameter logic [5:0] PART_NUM  = 6'h15  // Arbitrary value
) (
   // Clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_resetn,
   // Serial bus, data open drain
   input  wire logic       i_scl_clk,
   input  wire logic       i_sda,
   output logic            o_sda_o,
   output logic            o_sda_oe,
   // Pins
   input  wire logic [1:0] i_out_en_n,
   input  wire logic [1:0] i_pll_mode_strap,
   // Controls toward the analog core
   output logic      [1:0] o_out_en,
   output logic      [1:0] o_pll_mode,
   output logic      [1:0] o_amplitude,
   output logic      [1:0] o_edge_rate_out,
   output logic            o_edge_rate_feedback,
   output logic            o_freq_soft_en,
   output logic      [1:0] o_freq_code,
   output logic      [4:0] o_read_length
);

   // ==========================================================
   // Synchronised pins
   logic [1:0] bus_s;
   logic [1:0] oe_n_s;
   logic [1:0] strap_s;
   logic [7:0] link_byte;

   cbb_sync #(.WIDTH(2)) u_bus_sync (
      .i_ref_clk (i_ref_clk),
      .i_resetn  (i_resetn),
      .i_async   ({i_scl_clk, i_sda}),
      .o_sync    (bus_s)
   );

   cbb_sync #(.WIDTH(4)) u_pin_sync (
      .i_ref_clk (i_ref_clk),
      .i_resetn  (i_resetn),
      .i_async   ({i_out_en_n, i_pll_mode_strap}),
      .o_sync    ({oe_n_s, strap_s})
   );

   cbb_link_shift u_link (
      .i_scl_clk (i_scl_clk),
      .i_resetn  (i_resetn),
      .i_sda     (i_sda),
      .o_byte    (link_byte)
   );

   // ==========================================================
   // State
   cbb_pkg::cbb_state_t state_q;
   logic [3:0] cnt_q;
   logic [7:0] idx_q;
   logic [7:0] wleft_q;
   logic [7:0] tx_q;
   logic       ack_q;
   logic [1:0] bus_p_q;
   logic [7:0] oe_q;
   logic [7:0] mode_q;
   logic [7:0] slew_q;
   logic [7:0] freq_q;
   logic [7:0] bcnt_q;
   logic [1:0] latched_q;
   logic [1:0] strap_cnt_q;

   // Bus events from synchronised clock and data
   wire scl_s     = bus_s[1];
   wire sda_s     = bus_s[0];
   // Held off until the synchronisers leave their reset level
   wire bus_live  = strap_cnt_q == cbb_pkg::STRAP_WAIT;
   wire scl_rise  = bus_live & scl_s & ~bus_p_q[1];
   wire scl_fall  = bus_live & ~scl_s & bus_p_q[1];
   wire start_det = bus_live & scl_s & bus_p_q[1] & bus_p_q[0] & ~sda_s;
   wire stop_det  = bus_live & scl_s & bus_p_q[1] & ~bus_p_q[0] & sda_s;
   wire data_evt  = scl_rise & ~start_det & ~stop_det;
   wire byte_done = data_evt & (cnt_q == cbb_pkg::LAST_DATA_BIT);
   wire ack_rise  = data_evt & (cnt_q == cbb_pkg::ACK_SLOT);
   wire tx_state  = (state_q == cbb_pkg::ST_RCOUNT) |
                    (state_q == cbb_pkg::ST_RDATA);
   wire host_ack  = ack_rise & ~ack_q & tx_state;
   wire addr_hit  = link_byte[7:1] == cbb_pkg::BUS_ADDR;
   wire wr_stb    = byte_done & (state_q == cbb_pkg::ST_WDATA) &
                    (wleft_q != 8'h00);

   // Read value of each index, reserved bits forced
   wire [7:0] rd_mode = (mode_q & cbb_pkg::MODE_WMASK) |
                        cbb_pkg::MODE_RSVD |
                        {latched_q, 6'h00};
   wire [7:0] rd_byte =
      (idx_q == cbb_pkg::IDX_OE)   ? (oe_q | cbb_pkg::OE_RSVD) :
      (idx_q == cbb_pkg::IDX_MODE) ? rd_mode :
      (idx_q == cbb_pkg::IDX_SLEW) ? (slew_q | cbb_pkg::SLEW_RSVD) :
      (idx_q == cbb_pkg::IDX_FREQ) ? (freq_q | cbb_pkg::FREQ_RSVD) :
      (idx_q == cbb_pkg::IDX_RSVD) ? cbb_pkg::RSVD_VALUE :
      (idx_q == cbb_pkg::IDX_REV)  ? {REV_CODE, MAKER} :
      (idx_q == cbb_pkg::IDX_DEV)  ? {TYPE_CODE, PART_NUM} :
      (idx_q == cbb_pkg::IDX_BCNT) ? bcnt_q :
                                     cbb_pkg::NONE_VALUE;
   wire [7:0] rd_bcnt = bcnt_q;

   // Write data masked to writable bits only
   wire [7:0] wdata = link_byte;
   wire wr_oe   = wr_stb & (idx_q == cbb_pkg::IDX_OE);
   wire wr_mode = wr_stb & (idx_q == cbb_pkg::IDX_MODE);
   wire wr_slew = wr_stb & (idx_q == cbb_pkg::IDX_SLEW);
   wire wr_freq = wr_stb & (idx_q == cbb_pkg::IDX_FREQ);
   wire wr_bcnt = wr_stb & (idx_q == cbb_pkg::IDX_BCNT);

   // Effective controls
   wire       mode_ovr  = mode_q[cbb_pkg::MODE_OVR_BIT];
   wire [1:0] soft_mode = mode_q[cbb_pkg::MODE_SW_LO +: 2];
   wire       freq_en   = freq_q[cbb_pkg::FREQ_EN_BIT];
   wire [1:0] oe_soft   = {oe_q[cbb_pkg::OE1_BIT], oe_q[cbb_pkg::OE0_BIT]};

   // ==========================================================
   // Edge history of the synchronised bus lines
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         bus_p_q <= 2'h3;
      end else begin
         bus_p_q <= bus_s;
      end
   end

   // ==========================================================
   // Frame sequencer
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q <= cbb_pkg::ST_IDLE;
         cnt_q   <= 4'h0;
         idx_q   <= 8'h00;
         wleft_q <= 8'h00;
         tx_q    <= 8'h00;
         ack_q   <= 1'b0;
      end else if (start_det) begin
         state_q <= cbb_pkg::ST_ADDR;
         cnt_q   <= 4'h0;
         ack_q   <= 1'b0;
      end else if (stop_det) begin
         state_q <= cbb_pkg::ST_IDLE;
         cnt_q   <= 4'h0;
         ack_q   <= 1'b0;
      end else if (ack_rise) begin
         cnt_q <= 4'h0;
         ack_q <= 1'b0;
         if (host_ack && sda_s) begin
            state_q <= cbb_pkg::ST_IDLE;
         end else if (host_ack) begin
            tx_q    <= rd_byte;
            idx_q   <= idx_q + 8'h01;
            state_q <= cbb_pkg::ST_RDATA;
         end
      end else if (data_evt) begin
         cnt_q <= cnt_q + 4'h1;
         if (byte_done) begin
            case (state_q)
               cbb_pkg::ST_ADDR: begin
                  if (addr_hit) begin
                     ack_q <= 1'b1;
                     if (link_byte[0]) begin
                        state_q <= cbb_pkg::ST_RCOUNT;
                        tx_q    <= rd_bcnt;
                     end else begin
                        state_q <= cbb_pkg::ST_INDEX;
                     end
                  end else begin
                     state_q <= cbb_pkg::ST_IDLE;
                  end
               end
               cbb_pkg::ST_INDEX: begin
                  idx_q   <= link_byte;
                  ack_q   <= 1'b1;
                  state_q <= cbb_pkg::ST_COUNT;
               end
               cbb_pkg::ST_COUNT: begin
                  wleft_q <= link_byte;
                  ack_q   <= 1'b1;
                  state_q <= cbb_pkg::ST_WDATA;
               end
               cbb_pkg::ST_WDATA: begin
                  ack_q <= 1'b1;
                  if (wleft_q != 8'h00) begin
                     idx_q   <= idx_q + 8'h01;
                     wleft_q <= wleft_q - 8'h01;
                  end
               end
               default: begin
                  ack_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Data line driver, set while the bus clock is low, released at once on start or stop
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_sda_oe <= 1'b0;
      end else if (start_det || stop_det) begin
         o_sda_oe <= 1'b0;
      end else if (scl_fall) begin
         if (cnt_q == cbb_pkg::ACK_SLOT) begin
            o_sda_oe <= ack_q;
         end else if (tx_state) begin
            o_sda_oe <= ~tx_q[~cnt_q[2:0]];
         end else begin
            o_sda_oe <= 1'b0;
         end
      end
   end

   // Open drain only ever pulls low
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_sda_o <= 1'b0;
      end else begin
         o_sda_o <= 1'b0;
      end
   end

   // ==========================================================
   // Register file, only writable bits are stored
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         oe_q   <= cbb_pkg::OE_RST;
         mode_q <= cbb_pkg::MODE_RST;
         slew_q <= cbb_pkg::SLEW_RST;
         freq_q <= cbb_pkg::FREQ_RST;
         bcnt_q <= cbb_pkg::BCNT_RST;
      end else begin
         if (wr_oe)   oe_q   <= wdata & cbb_pkg::OE_WMASK;
         if (wr_mode) mode_q <= wdata & cbb_pkg::MODE_WMASK;
         if (wr_slew) slew_q <= wdata & cbb_pkg::SLEW_WMASK;
         if (wr_freq) freq_q <= wdata & cbb_pkg::FREQ_WMASK;
         if (wr_bcnt) bcnt_q <= wdata & cbb_pkg::BCNT_WMASK;
      end
   end

   // ==========================================================
   // PLL mode strap caught once the synchroniser has settled
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         strap_cnt_q <= 2'h0;
         latched_q   <= 2'h0;
      end else if (strap_cnt_q != cbb_pkg::STRAP_WAIT) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
         latched_q   <= strap_s;
      end
   end

   // ==========================================================
   // Output controls, each from a flop
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_out_en             <= 2'h0;
         o_pll_mode           <= 2'h0;
         o_amplitude          <= cbb_pkg::MODE_RST[1:0];
         o_edge_rate_out      <= {cbb_pkg::SLEW_RST[cbb_pkg::SLEW1_BIT],
                                  cbb_pkg::SLEW_RST[cbb_pkg::SLEW0_BIT]};
         o_edge_rate_feedback <= cbb_pkg::FREQ_RST[cbb_pkg::FBK_SLEW_BIT];
         o_freq_soft_en       <= 1'b0;
         o_freq_code          <= 2'h0;
         o_read_length        <= cbb_pkg::BCNT_RST[4:0];
      end else begin
         o_out_en    <= oe_soft & ~oe_n_s;
         o_pll_mode  <= mode_ovr ? soft_mode : latched_q;
         o_amplitude <= mode_q[cbb_pkg::AMP_LO +: 2];
         o_edge_rate_out <= {slew_q[cbb_pkg::SLEW1_BIT],
                             slew_q[cbb_pkg::SLEW0_BIT]};
         o_edge_rate_feedback <= freq_q[cbb_pkg::FBK_SLEW_BIT];
         o_freq_soft_en <= freq_en;
         o_freq_code    <= freq_en ? freq_q[cbb_pkg::FREQ_LO +: 2]
                                   : 2'h0;
         o_read_length  <= bcnt_q[4:0];
      end
   end

   // ==========================================================
   // Checks
   default clocking cb_ref @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_resetn);

   property p_oe_force;
      !oe_soft[0] |=> !o_out_en[0];
   endproperty
   a_oe_force: assert property (p_oe_force)
      else $error("output 0 not forced off");

   property p_mode_latched;
      !mode_ovr ##1 !mode_ovr |-> o_pll_mode == $past(latched_q);
   endproperty
   a_mode_latched: assert property (p_mode_latched)
      else $error("pll mode not from latched bits");

   property p_mode_soft;
      mode_ovr |=> o_pll_mode == $past(soft_mode);
   endproperty
   a_mode_soft: assert property (p_mode_soft)
      else $error("pll mode not from software bits");

   property p_freq_gate;
      !freq_en |=> o_freq_code == 2'h0 && !o_freq_soft_en;
   endproperty
   a_freq_gate: assert property (p_freq_gate)
      else $error("frequency code leaked while disabled");

   property p_rsvd_ff;
      idx_q == cbb_pkg::IDX_RSVD |-> rd_byte == cbb_pkg::RSVD_VALUE;
   endproperty
   a_rsvd_ff: assert property (p_rsvd_ff)
      else $error("reserved index not all ones");

   property p_addr_miss;
      byte_done && state_q == cbb_pkg::ST_ADDR && !addr_hit
         |=> state_q == cbb_pkg::ST_IDLE && !ack_q;
   endproperty
   a_addr_miss: assert property (p_addr_miss)
      else $error("foreign address answered");

   property p_ack_drive;
      scl_fall && !start_det && !stop_det &&
         cnt_q == cbb_pkg::ACK_SLOT && ack_q |=> o_sda_oe ##1 o_sda_oe;
   endproperty
   a_ack_drive: assert property (p_ack_drive)
      else $error("acknowledge not driven");

   property p_nack_end;
      host_ack && sda_s && !start_det && !stop_det
         |=> state_q == cbb_pkg::ST_IDLE;
   endproperty
   a_nack_end: assert property (p_nack_end)
      else $error("read did not end on host nack");

   property p_ro_kept;
      wr_mode |=> rd_mode[7:6] == latched_q &&
                  (rd_mode & cbb_pkg::MODE_RSVD) == cbb_pkg::MODE_RSVD &&
                  (mode_q & ~cbb_pkg::MODE_WMASK) == 8'h00;
   endproperty
   a_ro_kept: assert property (p_ro_kept)
      else $error("read-only mode bits changed by write");

endmodule // cbb_bank

/* File: design/cbb_link_shift.sv */
// Serial data capture running on the bus clock itself.
// Assumes data is stable around each rising bus clock edge; the
// reference domain reads the byte only after a synchronised edge.

module cbb_link_shift (
   // Link clock and reset
   input  wire logic       i_scl_clk,
   input  wire logic       i_resetn,
   // Serial data
   input  wire logic       i_sda,
   output logic      [7:0] o_byte
);

   // ==========================================================
   // Shift in one bit per rising bus clock edge
   always_ff @(posedge i_scl_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_byte <= 8'h00;
      end else begin
         o_byte <= {o_byte[6:0], i_sda};
      end
   end

   // Captured bit matches data at the bus clock edge
   property p_link_shift;
      @(posedge i_scl_clk) disable iff (!i_resetn)
         1'b1 |=> o_byte[0] == $past(i_sda);
   endproperty
   a_link_shift: assert property (p_link_shift)
      else $error("link shift lost a bit");

endmodule // cbb_link_shift

/* File: design/cbb_pkg.sv */
// Constants, register layout and state codes of the clock buffer bank.
// Assumes a byte-indexed register file behind a two-wire serial slave.
//
// Behaviour
// - Output enable bit at 0 forces its differential output low/low.
// - Latched PLL mode shows read-only in mode register bits 7 and 6.
// - Mode bit 5 picks PLL mode from latched bits or software bits.
// - Software PLL mode bits 4:3 act only when bit 5 is set.
// - Amplitude field bits 1:0 picks 0.6 to 0.9 V, resets to 10.
// - Slew bits 5 and 3 set per-output edge rate, fast after reset.
// - Frequency register bit 5 enables software frequency change.
// - Frequency code bits 4:3 are ignored unless bit 5 is set.
// - Frequency register bit 0 sets feedback edge rate, resets fast.
// - Index 4 is reserved and always reads FF.
// - Index 5 reads revision code high nibble, maker code low nibble.
// - Index 6 reads two-bit type code and six-bit part number.
// - Index 7 holds five-bit read length, default eight bytes.
// - Only bus address 1101101 is answered, direction bit appended.
// - Block write: address, index, count, then data bytes, each acked.
// - Block read: index, repeated start, read; host nacks last byte.

package cbb_pkg;

   // ==========================================================
   // Bus address and register indices
   localparam logic [6:0] BUS_ADDR = 7'h6D;
   localparam logic [7:0] IDX_OE   = 8'h00;
   localparam logic [7:0] IDX_MODE = 8'h01;
   localparam logic [7:0] IDX_SLEW = 8'h02;
   localparam logic [7:0] IDX_FREQ = 8'h03;
   localparam logic [7:0] IDX_RSVD = 8'h04;
   localparam logic [7:0] IDX_REV  = 8'h05;
   localparam logic [7:0] IDX_DEV  = 8'h06;
   localparam logic [7:0] IDX_BCNT = 8'h07;

   // ==========================================================
   // Field positions
   localparam int OE1_BIT      = 5;
   localparam int OE0_BIT      = 3;
   localparam int MODE_OVR_BIT = 5;
   localparam int MODE_SW_LO   = 3;
   localparam int AMP_LO       = 0;
   localparam int SLEW1_BIT    = 5;
   localparam int SLEW0_BIT    = 3;
   localparam int FREQ_EN_BIT  = 5;
   localparam int FREQ_LO      = 3;
   localparam int FBK_SLEW_BIT = 0;
   localparam int RB_LO        = 6;

   // ==========================================================
   // Writable masks, reserved read patterns, reset values
   localparam logic [7:0] OE_WMASK   = 8'h28;
   localparam logic [7:0] OE_RSVD    = 8'h86;
   localparam logic [7:0] OE_RST     = 8'h28;
   localparam logic [7:0] MODE_WMASK = 8'h3B;
   localparam logic [7:0] MODE_RSVD  = 8'h04;
   localparam logic [7:0] MODE_RST   = 8'h02;
   localparam logic [7:0] SLEW_WMASK = 8'h28;
   localparam logic [7:0] SLEW_RSVD  = 8'h07;
   localparam logic [7:0] SLEW_RST   = 8'h28;
   localparam logic [7:0] FREQ_WMASK = 8'h39;
   localparam logic [7:0] FREQ_RSVD  = 8'h06;
   localparam logic [7:0] FREQ_RST   = 8'h01;
   localparam logic [7:0] BCNT_WMASK = 8'h1F;
   localparam logic [7:0] BCNT_RST   = 8'h08;
   localparam logic [7:0] RSVD_VALUE = 8'hFF;
   localparam logic [7:0] NONE_VALUE = 8'h00;

   // ==========================================================
   // Serial framing and start-up counts
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_SLOT      = 4'h8;
   localparam logic [1:0] STRAP_WAIT    = 2'h3;

   typedef enum logic [6:0] {
      ST_IDLE   = 7'h01,
      ST_ADDR   = 7'h02,
      ST_INDEX  = 7'h04,
      ST_COUNT  = 7'h08,
      ST_WDATA  = 7'h10,
      ST_RCOUNT = 7'h20,
      ST_RDATA  = 7'h40
   } cbb_state_t;

endpackage

/* File: design/cbb_sync.sv */
// Two-flop level synchroniser into the reference clock domain.
// Assumes inputs are levels that hold for several destination cycles.

module cbb_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             i_ref_clk,
   input  wire logic             i_resetn,
   // Levels
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_q;

   // ==========================================================
   // Two stages; first stage feeds only the second
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         meta_q <= '0;
         o_sync <= '0;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule // cbb_sync

/* File: tb/cbb_host.sv */
// ==========================================================
// Bus master model driving the two-wire serial pins.
// Assumes the data wire is resolved outside with a pull-up.
module cbb_host (
   // Serial bus
   output logic      o_scl,
   output logic      o_sda_oe,
   input  wire logic i_sda
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam realtime HALF = 24.0;
   localparam realtime LAG  = 8.3;

   // Bus idle: clock stopped high, data released
   initial begin
      o_scl    = 1'b1;
      o_sda_oe = 1'b0;
   end

   // One bit slot; data moves well after the clock falls
   task automatic put_bit(input logic v, output logic s);
      #LAG o_sda_oe = ~v;
      #(HALF - LAG) o_scl = 1'b1;
      s = i_sda;
      #HALF o_scl = 1'b0;
   endtask

   // Start or repeated start: data falls with clock high
   task automatic start_cond();
      #LAG o_sda_oe = 1'b0;
      #HALF o_scl = 1'b1;
      #HALF o_sda_oe = 1'b1;
      #HALF o_scl = 1'b0;
   endtask

   // Stop: data rises with clock high, clock then stands
   task automatic stop_cond();
      #LAG o_sda_oe = 1'b1;
      #HALF o_scl = 1'b1;
      #HALF o_sda_oe = 1'b0;
      #HALF;
   endtask

   // Byte out MSB first, address with direction bit last
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i], s);
      end
      put_bit(1'b1, s);
      ack = ~s;
   endtask

   // Byte in, then host ack, or nack on the last byte
   task automatic get_byte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, d[i]);
      end
      put_bit(nack, s);
   endtask
endmodule // cbb_host

/* File: tb/test_clock_buffer_smbus_control_bank.sv */
// ==========================================================
// Self-checking bench of the clock buffer register bank.
// Assumes the host model drives the serial pins.
module test_clock_buffer_smbus_control_bank;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [3:0] REV  = 4'hA;  // Arbitrary value
   localparam logic [3:0] MKR  = 4'h5;  // Arbitrary value
   localparam logic [1:0] TYP  = 2'h3;  // Arbitrary value
   localparam logic [5:0] PNUM = 6'h2A; // Arbitrary value
   localparam logic [7:0] WA   = {cbb_pkg::BUS_ADDR, 1'b0};
   logic        clk, rst_n, scl, h_oe, d_o, d_oe, erf, fen, a;
   wire  logic  sda;
   logic [1:0]  pin_n, strap, oen, pll, amp, er, fc;
   logic [4:0]  rlen;
   logic [7:0]  m [8];
   logic [31:0] rnd;
   int          bad_count, total_checks;

   // Open-drain data wire with pull-up
   assign sda = ~h_oe & (~d_oe | d_o);

   // Reference clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   cbb_bank #(.REV_CODE(REV), .MAKER(MKR), .TYPE_CODE(TYP),
              .PART_NUM(PNUM)) dut (
      .i_ref_clk            (clk),
      .i_resetn             (rst_n),
      .i_scl_clk            (scl),
      .i_sda                (sda),
      .o_sda_o              (d_o),
      .o_sda_oe             (d_oe),
      .i_out_en_n           (pin_n),
      .i_pll_mode_strap     (strap),
      .o_out_en             (oen),
      .o_pll_mode           (pll),
      .o_amplitude          (amp),
      .o_edge_rate_out      (er),
      .o_edge_rate_feedback (erf),
      .o_freq_soft_en       (fen),
      .o_freq_code          (fc),
      .o_read_length        (rlen)
   );

   cbb_host host (
      .o_scl    (scl),
      .o_sda_oe (h_oe),
      .i_sda    (sda)
   );

   // Random source
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Writable bits of each index
   function automatic logic [7:0] wmask(input int i);
      case (i)
         0: return cbb_pkg::OE_WMASK;
         1: return cbb_pkg::MODE_WMASK;
         2: return cbb_pkg::SLEW_WMASK;
         3: return cbb_pkg::FREQ_WMASK;
         7: return cbb_pkg::BCNT_WMASK;
         default: return 8'h00;
      endcase
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Block write of all eight indices from zero
   task automatic wr_all(input int mode);
      logic [7:0] d;
      host.start_cond();
      host.put_byte(WA, a);
      check(8'(a), 8'h01);
      host.put_byte(8'h00, a);
      check(8'(a), 8'h01);
      host.put_byte(8'h08, a);
      check(8'(a), 8'h01);
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         d = (mode == 0) ? 8'h00 : (mode == 1) ? 8'hFF : rnd[7:0];
         host.put_byte(d, a);
         check(8'(a), 8'h01);
         m[i] = (d & wmask(i)) | (m[i] & ~wmask(i));
      end
      host.stop_cond();
   endtask

   // Block read: count byte, then indices zero to seven
   task automatic rd_all();
      logic [7:0] d;
      host.start_cond();
      host.put_byte(WA, a);
      host.put_byte(8'h00, a);
      host.start_cond();
      host.put_byte(WA | 8'h01, a);
      check(8'(a), 8'h01);
      host.get_byte(1'b0, d);
      check(d, m[7]);
      for (int i = 0; i < 8; i++) begin
         host.get_byte(i == 7, d);
         check(d, m[i]);
      end
      host.stop_cond();
   endtask

   // Controls toward the analog core
   task automatic check_outs();
      repeat (20) @(posedge clk);
      check(8'(oen), 8'({m[0][5] & ~pin_n[1],
                         m[0][3] & ~pin_n[0]}));
      check(8'(pll), 8'(m[1][5] ? m[1][4:3] : strap));
      check(8'(amp), 8'(m[1][1:0]));
      check(8'(er), 8'({m[2][5], m[2][3]}));
      check(8'(fen), 8'(m[3][5]));
      check(8'(fc), 8'(m[3][5] ? m[3][4:3] : 2'b00));
      check(8'(erf), 8'(m[3][0]));
      check(8'(rlen), 8'(m[7][4:0]));
      check(8'(d_o), 8'h00);
   endtask

   // Main sequence
   initial begin
      rnd = lfsr(32'h0000_E902);
      strap = rnd[1:0];
      pin_n = 2'b00;
      rst_n = 1'b0;
      bad_count = 0;
      total_checks = 0;
      m = '{cbb_pkg::OE_RST | cbb_pkg::OE_RSVD,
            {strap, 6'h00} | cbb_pkg::MODE_RST | cbb_pkg::MODE_RSVD,
            cbb_pkg::SLEW_RST | cbb_pkg::SLEW_RSVD,
            cbb_pkg::FREQ_RST | cbb_pkg::FREQ_RSVD,
            cbb_pkg::RSVD_VALUE, {REV, MKR}, {TYP, PNUM},
            cbb_pkg::BCNT_RST};
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      check_outs();
      host.start_cond();
      host.put_byte(8'hD8, a);
      check(8'(a), 8'h00);
      host.put_byte(8'h00, a);
      host.put_byte(8'h00, a);
      host.stop_cond();
      rd_all();
      for (int r = 0; r < 4; r++) begin
         @(posedge clk);
         #1 rnd = lfsr(rnd);
         pin_n = rnd[1:0];
         wr_all(r);
         check_outs();
         rd_all();
      end
      complete_run();
   end

   // Hang guard
   initial begin
      #200_000;
      bad_count++;
      complete_run();
   end
endmodule // test_clock_buffer_smbus_control_bank
